/* File: logic/fan_boost_ramp.sv */
// Fan PWM override logic: hot input ramps, zone boost hysteresis,
// smart tach enables and input threshold selects, with their registers.
// Assumes a byte register port from the management bus front end and
// zone temperatures and limits from logic on the same clock.
//
// Function
// - Low four control bits enable tach smart mode
// - Threshold register selects lower input levels
// - Bits 3:0 pace regulator hot ramp
// - Bits 7:4 pace processor hot ramp
// - Interval is code times 50 ms
// - Code zero gives full duty at once
// - Hysteresis register: zone1 low, zone2 high
// - Boost holds full duty until below hysteresis
// - Hysteresis is unsigned 0 to 15 degrees
module fan_boost_ramp
  import fan_ctrl_pkg::*;
#(
  parameter int MS_CYCLES = CYCLES_PER_MS // Clock cycles per millisecond
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [1:0] regulator_overtemp_input_n_i,
  input wire logic [1:0] cpu_overtemp_input_n_i,
  input wire logic [1:0][7:0] zone_temp_i,
  input wire logic [1:0][7:0] zone_boost_limit_i,
  input wire pwm_pair_t base_duty_i,
  output logic [7:0] reg_rdata_o,
  output pwm_pair_t pwm_duty_o,
  output logic [3:0] tach_smart_enable_o,
  output logic [3:0] gp_input_low_threshold_o,
  output logic [1:0] cpu_vid_low_threshold_o
);

  localparam int MS_W = $clog2(MS_CYCLES + 1);

  // Register file
  logic [7:0] smart_tach_reg; // Smart tach enables and resolution bits
  logic [7:0] threshold_sel_reg; // Input level selects
  logic [7:0] ramp_interval_reg; // Both ramp interval codes
  logic [7:0] boost_hyst_reg; // Zone 1 and 2 boost hysteresis

  // Decode of the register port
  wire wr_en = ce_i && reg_wr_i;
  wire wr_tach = wr_en && (reg_addr_i == ADDR_SMART_TACH_CTRL);
  wire wr_thr = wr_en && (reg_addr_i == ADDR_THRESHOLD_SEL);
  wire wr_ramp = wr_en && (reg_addr_i == ADDR_RAMP_INTERVAL);
  wire wr_hyst = wr_en && (reg_addr_i == ADDR_BOOST_HYST12);

  // Read multiplexer; unmapped offsets read as zero
  logic [7:0] rdata_sel;
  assign rdata_sel =
    (reg_addr_i == ADDR_SMART_TACH_CTRL) ? smart_tach_reg :
    (reg_addr_i == ADDR_THRESHOLD_SEL) ? threshold_sel_reg :
    (reg_addr_i == ADDR_RAMP_INTERVAL) ? ramp_interval_reg :
    (reg_addr_i == ADDR_BOOST_HYST12) ? boost_hyst_reg : 8'h0000;

  // Register writes; reserved bits are masked so they stay zero
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      smart_tach_reg <= SMART_TACH_RESET;
      threshold_sel_reg <= THRESHOLD_SEL_RESET;
      ramp_interval_reg <= RAMP_INTERVAL_RESET;
      boost_hyst_reg <= BOOST_HYST_RESET;
    end else begin
      if (wr_tach) begin
        smart_tach_reg <= reg_wdata_i & SMART_TACH_WMASK;
      end
      if (wr_thr) begin
        threshold_sel_reg <= reg_wdata_i & THRESHOLD_SEL_WMASK;
      end
      if (wr_ramp) begin
        ramp_interval_reg <= reg_wdata_i;
      end
      if (wr_hyst) begin
        boost_hyst_reg <= reg_wdata_i;
      end
    end
  end

  // Read data is registered; holds between reads
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h0000;
    end else if (ce_i && reg_rd_i) begin
      reg_rdata_o <= rdata_sel;
    end
  end

  // Configuration outputs come straight from the register flops.
  // Software alone must keep smart tach off at 22.5 kHz and set the
  // tach binding first; nothing here checks that combination.
  assign tach_smart_enable_o = smart_tach_reg[TACH_EN_LSB +: 4];
  assign gp_input_low_threshold_o =
    threshold_sel_reg[GP_LVL_LSB +: 4];
  assign cpu_vid_low_threshold_o =
    threshold_sel_reg[VID_LVL_LSB +: 2];

  // Two-stage synchronisers for the asynchronous hot pins
  logic [3:0] hot_meta_reg, hot_sync_reg;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      hot_meta_reg <= 4'h000F;
      hot_sync_reg <= 4'h000F;
    end else if (ce_i) begin
      hot_meta_reg <= {cpu_overtemp_input_n_i,
                       regulator_overtemp_input_n_i};
      hot_sync_reg <= hot_meta_reg;
    end
  end

  // Either pin of a pair asserts that group's ramp (pins are active low)
  wire regulator_hot = ~&hot_sync_reg[1:0];
  wire cpu_hot = ~&hot_sync_reg[3:2];

  // Millisecond tick; a pulse keeps both ramp timers cheap
  logic [MS_W-1:0] ms_div_reg;
  logic ms_tick_reg;
  wire ms_wrap = (ms_div_reg == MS_W'(MS_CYCLES - 1));
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ms_div_reg <= '0;
      ms_tick_reg <= 1'b0;
    end else if (ce_i) begin
      ms_div_reg <= ms_wrap ? '0 : ms_div_reg + MS_W'(1);
      ms_tick_reg <= ms_wrap;
    end
  end

  // Ramp interval codes for each group of hot inputs
  wire [3:0] regulator_hot_step_interval =
    ramp_interval_reg[REG_RAMP_LSB +: 4];
  wire [3:0] cpu_hot_step_interval =
    ramp_interval_reg[CPU_RAMP_LSB +: 4];

  logic [7:0] reg_ramp_duty, cpu_ramp_duty;

  ramp_stepper u_regulator_ramp (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .ms_tick_i(ms_tick_reg),
    .hot_i(regulator_hot),
    .code_i(regulator_hot_step_interval),
    .duty_o(reg_ramp_duty)
  );

  ramp_stepper u_cpu_ramp (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .ms_tick_i(ms_tick_reg),
    .hot_i(cpu_hot),
    .code_i(cpu_hot_step_interval),
    .duty_o(cpu_ramp_duty)
  );

  // Boost latch per zone with unsigned hysteresis in whole degrees
  logic [1:0] boost_reg;
  logic [1:0] boost_set, boost_clr;
  genvar z;
  generate
    for (z = 0; z < 2; z++) begin : g_zone
      wire [ZONE_HYST_W-1:0] hyst =
        boost_hyst_reg[z*ZONE_HYST_W +: ZONE_HYST_W];
      assign boost_set[z] = zone_temp_i[z] > zone_boost_limit_i[z];
      // Wide sum: limit minus temp must exceed hyst, no wrap
      assign boost_clr[z] = ({1'b0, zone_temp_i[z]} + 9'(hyst)) <
                            {1'b0, zone_boost_limit_i[z]};
      always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
          boost_reg[z] <= 1'b0;
        end else if (ce_i) begin
          if (boost_set[z]) begin
            boost_reg[z] <= 1'b1;
          end else if (boost_clr[z]) begin
            boost_reg[z] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Highest demand wins on each output
  function automatic logic [7:0] max3(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic [7:0] c);
    logic [7:0] m;
    m = (a > b) ? a : b;
    max3 = (m > c) ? m : c;
  endfunction

  wire boost_any = |boost_reg;
  pwm_pair_t duty_next;
  assign duty_next.pwm1 = boost_any ? DUTY_FULL :
    max3(base_duty_i.pwm1, reg_ramp_duty, cpu_ramp_duty);
  assign duty_next.pwm2 = boost_any ? DUTY_FULL :
    max3(base_duty_i.pwm2, reg_ramp_duty, cpu_ramp_duty);

  // Output duty register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pwm_duty_o <= '0;
    end else if (ce_i) begin
      pwm_duty_o <= duty_next;
    end
  end

  chk_tach_enable_wr: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    wr_tach |=> tach_smart_enable_o == $past(reg_wdata_i[3:0]))
    else $error("smart tach enables differ from write");

  chk_level_select_wr: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    wr_thr |=> gp_input_low_threshold_o == $past(reg_wdata_i[7:4]) &&
    cpu_vid_low_threshold_o == $past(reg_wdata_i[1:0]) &&
    threshold_sel_reg[3:2] == 2'h0)
    else $error("threshold selects differ from write");

  chk_reg_ramp_field: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    wr_ramp |=> regulator_hot_step_interval == $past(reg_wdata_i[3:0]))
    else $error("regulator ramp code not from bits 3:0");

  chk_cpu_ramp_field: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    wr_ramp |=> cpu_hot_step_interval == $past(reg_wdata_i[7:4]))
    else $error("processor ramp code not from bits 7:4");

  chk_hyst_fields: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    wr_hyst |=> g_zone[0].hyst == $past(reg_wdata_i[3:0]) &&
    g_zone[1].hyst == $past(reg_wdata_i[7:4]))
    else $error("hysteresis fields misplaced");

  chk_boost_full_duty: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    ce_i && boost_any |=> pwm_duty_o.pwm1 == DUTY_FULL &&
    pwm_duty_o.pwm2 == DUTY_FULL)
    else $error("boost active without full duty");

  chk_boost_hold_band: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    ce_i && boost_reg[0] && zone_boost_limit_i[0] - zone_temp_i[0] <=
    8'(g_zone[0].hyst) && zone_temp_i[0] <= zone_boost_limit_i[0]
    |=> boost_reg[0])
    else $error("zone 1 boost released inside hysteresis");

  chk_boost_release: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    ce_i && !boost_set[1] && boost_clr[1] |=> !boost_reg[1])
    else $error("zone 2 boost not released below hysteresis");

  cov_boost_enter: cover property (@(posedge clk_i) disable iff (!resetn_i)
    !boost_reg[0] ##1 boost_reg[0]);

  cov_boost_exit: cover property (@(posedge clk_i) disable iff (!resetn_i)
    boost_reg[1] ##1 !boost_reg[1]);

  cov_both_hot: cover property (@(posedge clk_i) disable iff (!resetn_i)
    regulator_hot && cpu_hot);

endmodule

/* File: inc/fan_ctrl_pkg.sv */
// Shared constants and types for the fan ramp and boost control block.
// Assumes a single 20 MHz clock and a byte-wide register port.
package fan_ctrl_pkg;

  // Register offsets on the byte-wide register port
  localparam logic [7:0] ADDR_SMART_TACH_CTRL = 8'h00_BD;
  localparam logic [7:0] ADDR_THRESHOLD_SEL = 8'h00_BE;
  localparam logic [7:0] ADDR_RAMP_INTERVAL = 8'h00_BF;
  localparam logic [7:0] ADDR_BOOST_HYST12 = 8'h00_C0;

  // Reset values
  localparam logic [7:0] SMART_TACH_RESET = 8'h0000;
  localparam logic [7:0] THRESHOLD_SEL_RESET = 8'h0000;
  localparam logic [7:0] RAMP_INTERVAL_RESET = 8'h0000;
  localparam logic [7:0] BOOST_HYST_RESET = 8'h0000;

  // Writable bit masks; masked-off bits are reserved and read as zero
  localparam logic [7:0] SMART_TACH_WMASK = 8'h003F;
  localparam logic [7:0] THRESHOLD_SEL_WMASK = 8'h00F3;

  // Field positions
  localparam int TACH_EN_LSB = 0;
  localparam int GP_LVL_LSB = 4;
  localparam int VID_LVL_LSB = 0;
  localparam int REG_RAMP_LSB = 0;
  localparam int CPU_RAMP_LSB = 4;
  localparam int ZONE_HYST_W = 4;

  // Timing: ramp interval is code times 50 ms
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_SEC = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_SEC;
  localparam logic [9:0] RAMP_STEP_MS = 10'h0032;

  // Duty values and step size
  localparam logic [7:0] DUTY_FULL = 8'h00FF;
  localparam logic [7:0] DUTY_OFF = 8'h0000;
  localparam logic [7:0] DUTY_STEP = 8'h0010;

  // Ramp stepper states
  typedef enum logic [1:0] {RAMP_IDLE, RAMP_UP, RAMP_DOWN} ramp_state_t;

  // Duty values for the two PWM outputs
  typedef struct packed {
    logic [7:0] pwm2;
    logic [7:0] pwm1;
  } pwm_pair_t;

endpackage

/* File: logic/ramp_stepper.sv */
// Duty ramp for one group of hot inputs.
// Assumes ms_tick_i is a one-cycle pulse once per millisecond, same clock.
module ramp_stepper
  import fan_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic ms_tick_i,
  input wire logic hot_i,
  input wire logic [3:0] code_i,
  output logic [7:0] duty_o
);

  ramp_state_t state_reg, state_next; // Ramp direction
  logic [9:0] ms_cnt_reg, ms_cnt_next; // Milliseconds since last step
  logic [7:0] duty_reg, duty_next; // Present override duty
  wire [9:0] interval_ms; // Step interval in ms
  wire elapse; // Interval has run out this cycle
  wire code_zero; // Immediate mode
  wire [8:0] duty_up; // Wide sum to catch overflow
  wire [7:0] duty_up_sat;
  wire [7:0] duty_dn_sat;

  // Linear code to time map, 50 ms per code step
  assign interval_ms = 10'(code_i * RAMP_STEP_MS);
  assign code_zero = (code_i == 4'h0000);
  // Use >= so a shortened interval written mid-ramp cannot stall
  assign elapse = ms_tick_i && !code_zero &&
                  (ms_cnt_reg >= interval_ms - 10'h0001);
  assign duty_up = {1'b0, duty_reg} + {1'b0, DUTY_STEP};
  assign duty_up_sat = duty_up[8] ? DUTY_FULL : duty_up[7:0];
  assign duty_dn_sat = (duty_reg > DUTY_STEP) ? duty_reg - DUTY_STEP
                                              : DUTY_OFF;

  // Next-state logic of the stepper
  always_comb begin
    state_next = state_reg;
    duty_next = duty_reg;
    ms_cnt_next = ms_tick_i ? ms_cnt_reg + 10'h0001 : ms_cnt_reg;
    if (hot_i && code_zero) begin
      // Zero interval: straight to full duty
      state_next = RAMP_UP;
      duty_next = DUTY_FULL;
      ms_cnt_next = 10'h0000;
    end else if (hot_i) begin
      state_next = RAMP_UP;
      if (elapse) begin
        duty_next = duty_up_sat;
        ms_cnt_next = 10'h0000;
      end
    end else begin
      case (state_reg)
        RAMP_UP, RAMP_DOWN: begin
          state_next = RAMP_DOWN;
          if (duty_reg == DUTY_OFF) begin
            state_next = RAMP_IDLE;
          end else if (code_zero) begin
            // No ramp time, so release at once too
            duty_next = DUTY_OFF;
          end else if (elapse) begin
            duty_next = duty_dn_sat;
            ms_cnt_next = 10'h0000;
          end
        end
        RAMP_IDLE: begin
          ms_cnt_next = 10'h0000;
          duty_next = DUTY_OFF;
        end
        default: begin
          state_next = RAMP_IDLE;
        end
      endcase
    end
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_reg <= RAMP_IDLE;
      ms_cnt_reg <= 10'h0000;
      duty_reg <= DUTY_OFF;
    end else if (ce_i) begin
      state_reg <= state_next;
      ms_cnt_reg <= ms_cnt_next;
      duty_reg <= duty_next;
    end
  end

  assign duty_o = duty_reg;

  chk_zero_full: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && hot_i && code_zero |=> duty_reg == DUTY_FULL)
    else $error("zero interval did not give full duty");

  chk_step_up: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && hot_i && elapse |=> duty_reg == $past(duty_up_sat))
    else $error("ramp did not step up on interval");

  chk_no_early_step: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    ce_i && hot_i && !code_zero && !ms_tick_i
    |=> duty_reg == $past(duty_reg))
    else $error("duty moved between interval ticks");

  chk_interval_len: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    elapse |-> ms_cnt_reg + 10'h0001 >= 10'(code_i * 10'h0032))
    else $error("ramp step came before its interval");

  cov_ramp_full: cover property (@(posedge clk_i) disable iff (!resetn_i)
    hot_i && !code_zero && duty_reg == DUTY_FULL);

  cov_ramp_down: cover property (@(posedge clk_i) disable iff (!resetn_i)
    state_reg == RAMP_DOWN && elapse);

endmodule

/* File: verification/fan_env_model.sv */
// Far side of the fan block: hot signal sources and zone temperature feed.
// Assumes the bench asks for hot levels and temperatures on the same clock.
module fan_env_model (
  input wire logic clk_i,
  input wire logic [1:0] reg_hot_i,
  input wire logic [1:0] cpu_hot_i,
  input wire logic [1:0][7:0] temp_i,
  output logic [1:0] regulator_overtemp_input_n_o,
  output logic [1:0] cpu_overtemp_input_n_o,
  output logic [1:0][7:0] zone_temp_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Hot lines are pulled up, so they idle high and not hot
  initial begin
    regulator_overtemp_input_n_o = 2'b11;
    cpu_overtemp_input_n_o = 2'b11;
    zone_temp_o = '0;
  end

  // Pins move just after an edge, like a source from another clock
  always @(posedge clk_i) begin
    regulator_overtemp_input_n_o <= ~reg_hot_i;
    cpu_overtemp_input_n_o <= ~cpu_hot_i;
    zone_temp_o <= temp_i;
  end
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the fan ramp and boost block.
// Assumes MS_CYCLES of 4, so one 50 ms ramp step is 200 clocks.
`define CHECK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module testbench;
  import fan_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i, resetn_i, ce_i, reg_wr_i, reg_rd_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, lfsr, exp_b;
  logic [1:0] reg_hot, cpu_hot; // Hot requests to the far side model
  logic [1:0] regulator_overtemp_input_n_i, cpu_overtemp_input_n_i;
  logic [1:0][7:0] temp_req, zone_temp_i, zone_boost_limit_i;
  pwm_pair_t base_duty_i, pwm_duty_o, exp_p;
  logic [3:0] tach_smart_enable_o, gp_input_low_threshold_o;
  logic [1:0] cpu_vid_low_threshold_o;
  logic rd_seen, pwm_go; // Result markers for the watcher
  logic [7:0] rq[$]; // Expected read data, oldest first
  pwm_pair_t pq[$]; // Expected duty pairs, oldest first
  int n_mismatch = 0;
  int n_tests = 0;

  fan_boost_ramp #(.MS_CYCLES(4)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i),
    .regulator_overtemp_input_n_i(regulator_overtemp_input_n_i),
    .cpu_overtemp_input_n_i(cpu_overtemp_input_n_i),
    .zone_temp_i(zone_temp_i), .zone_boost_limit_i(zone_boost_limit_i),
    .base_duty_i(base_duty_i), .reg_rdata_o(reg_rdata_o),
    .pwm_duty_o(pwm_duty_o), .tach_smart_enable_o(tach_smart_enable_o),
    .gp_input_low_threshold_o(gp_input_low_threshold_o),
    .cpu_vid_low_threshold_o(cpu_vid_low_threshold_o)
  );

  fan_env_model env (
    .clk_i(clk_i), .reg_hot_i(reg_hot), .cpu_hot_i(cpu_hot),
    .temp_i(temp_req),
    .regulator_overtemp_input_n_o(regulator_overtemp_input_n_i),
    .cpu_overtemp_input_n_o(cpu_overtemp_input_n_i),
    .zone_temp_o(zone_temp_i)
  );

  // Free-running 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Eight-bit shift register for stimulus values
  function automatic logic [7:0] next_rand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // One register write, strobe held for exactly one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // One register read; the watcher compares the answer
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask

  // Note an expected duty for both outputs and mark the sample point
  task automatic chk_pwm(input logic [7:0] d);
    pq.push_back(pwm_pair_t'{d, d});
    pwm_go <= 1'b1;
    @(posedge clk_i);
    pwm_go <= 1'b0;
  endtask

  // Three steps up while hot, three steps down after release
  task automatic ramp(input logic [1:0] rh, input logic [1:0] ch,
                      input int per);
    reg_hot <= rh;
    cpu_hot <= ch;
    // Sample mid-step, since the first step has a 1 ms phase slack
    repeat (per / 2) @(posedge clk_i);
    for (int k = 1; k <= 3; k++) begin
      repeat (per - 1) @(posedge clk_i);
      chk_pwm(8'(k * 16));
    end
    reg_hot <= 2'b00;
    cpu_hot <= 2'b00;
    repeat (per / 2) @(posedge clk_i);
    for (int k = 2; k >= 0; k--) begin
      repeat (per - 1) @(posedge clk_i);
      chk_pwm(8'(k * 16));
    end
  endtask

  // Verdict, reached from the main sequence or the watchdog
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watcher: takes the oldest note whenever a result appears
  always @(posedge clk_i) begin
    rd_seen <= reg_rd_i && ce_i && resetn_i;
    if (rd_seen) begin
      exp_b = rq.pop_front();
      `CHECK(reg_rdata_o, exp_b)
    end
    if (pwm_go) begin
      exp_p = pq.pop_front();
      `CHECK(pwm_duty_o, exp_p)
    end
  end

  // Watchdog, well beyond the roughly 4400 clocks the tests need
  initial begin
    #(12000 * 50);
    n_mismatch++;
    complete_run();
  end

  // Main sequence
  initial begin
    logic [7:0] adr[4];
    logic [7:0] msk[4];
    logic [7:0] bt[6];
    logic [7:0] r;
    adr = '{ADDR_SMART_TACH_CTRL, ADDR_THRESHOLD_SEL, ADDR_RAMP_INTERVAL,
            ADDR_BOOST_HYST12};
    msk = '{SMART_TACH_WMASK, THRESHOLD_SEL_WMASK, 8'h00FF, 8'h00FF};
    bt = '{8'h003D, 8'h0039, 8'h0038, 8'h003D, 8'h002D, 8'h002C};
    resetn_i = 1'b0;
    ce_i = 1'b1;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_hot = '0;
    cpu_hot = '0;
    temp_req = '0;
    zone_boost_limit_i = {8'h003C, 8'h003C}; // Boost at 60 degrees
    base_duty_i = '0;
    pwm_go = 1'b0;
    lfsr = 8'h005C;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    // Reset values, then one unmapped offset
    for (int i = 0; i < 4; i++) rd(adr[i], 8'h0000);
    rd(8'h0010, 8'h0000);
    // Random bytes; reserved bits must read back as zero.
    // No fast PWM rate exists here, so any tach enable pattern is legal
    for (int n = 0; n < 3; n++) begin
      for (int i = 0; i < 4; i++) begin
        lfsr = next_rand(lfsr);
        wr(adr[i], lfsr);
        rd(adr[i], lfsr & msk[i]);
        if (i == 0) `CHECK(tach_smart_enable_o, lfsr[3:0])
        if (i == 1) `CHECK(gp_input_low_threshold_o, lfsr[7:4])
        if (i == 1) `CHECK(cpu_vid_low_threshold_o, lfsr[1:0])
      end
    end
    // Clock enable low must ignore a write
    wr(ADDR_RAMP_INTERVAL, 8'h0021);
    ce_i <= 1'b0;
    wr(ADDR_RAMP_INTERVAL, 8'h00FF);
    ce_i <= 1'b1;
    rd(ADDR_RAMP_INTERVAL, 8'h0021);
    // Code zero: full duty at once, base duty again on release
    wr(ADDR_RAMP_INTERVAL, 8'h00F0);
    base_duty_i <= '{8'h0020, 8'h0020};
    reg_hot <= 2'b10;
    repeat (8) @(posedge clk_i);
    chk_pwm(8'h00FF);
    reg_hot <= 2'b00;
    repeat (8) @(posedge clk_i);
    chk_pwm(8'h0020);
    // Regulator code 1 and processor code 2 pace different step times
    wr(ADDR_RAMP_INTERVAL, 8'h0021);
    base_duty_i <= '0;
    ramp(2'b01, 2'b00, 200);
    ramp(2'b00, 2'b10, 400);
    // Boost: zone 1 hysteresis 3, zone 2 hysteresis 15
    wr(ADDR_BOOST_HYST12, 8'h00F3);
    lfsr = next_rand(lfsr);
    r = lfsr & 8'h007F;
    base_duty_i <= '{r, r};
    for (int i = 0; i < 6; i++) begin
      temp_req <= (i >= 3) ? {bt[i], 8'h0000} : {8'h0000, bt[i]};
      repeat (6) @(posedge clk_i);
      chk_pwm((i % 3 == 2) ? r : 8'h00FF);
    end
    repeat (4) @(posedge clk_i);
    complete_run();
  end
endmodule
